// File: src/sodw_defines.svh
// timing counts and widths for the dynamic termination block
// assumes one clock at 20 MHz; all counts are whole input clock cycles
`ifndef SODW_DEFINES_SVH
`define SODW_DEFINES_SVH

`define SODW_CLK_PERIOD_NS 50
`define SODW_ODT_HIGH_MIN_SHORT 4'h4
`define SODW_ODT_HIGH_MIN_LONG 4'h6
`define SODW_NOM_TO_WRITE_SUB 5'h02
`define SODW_WRITE_TO_NOM_CHOP 6'h04
`define SODW_WRITE_TO_NOM_FULL 6'h06
`define SODW_WRLVL_FIRST_STROBE_WAIT 8'h28
`define SODW_HIST_W 32
`define SODW_CNT_W 8
`define SODW_CNT_MAX 8'hff

`endif

// File: src/sodw_pkg.sv
// types for the dynamic termination block, and the count function it shares with its cycle timer
// assumes sodw_defines.svh is on the include path
`include "sodw_defines.svh"

package sodw_pkg;

	typedef enum logic [2:0] {
		SODW_TERM_OFF = 3'h1,
		SODW_TERM_NOM = 3'h2,
		SODW_TERM_WR = 3'h4
	} sodw_term_t;

	typedef struct packed {
		sodw_term_t term;
		logic [`SODW_HIST_W-1:0] hist;
		logic dly;
		logic wr_active;
		logic chop;
		logic [3:0] hi_cnt;
		logic hi_long;
		logic odt_err;
		logic wrlvl_q;
		logic lvl_err;
	} sodw_state_t;

	// saturating count of clock edges since a start pulse
	function automatic logic [`SODW_CNT_W-1:0] sodw_next_count(
		input logic [`SODW_CNT_W-1:0] cnt,
		input logic start);
		if (start)
			return `SODW_CNT_W'(1);
		else if (cnt == `SODW_CNT_MAX)
			return cnt;
		else
			return cnt + `SODW_CNT_W'(1);
	endfunction

endpackage

// File: src/sodw_tmr_if.sv
// start pulse and elapsed cycle count between the block and a cycle timer
// assumes both ends share one clock
interface sodw_tmr_if #(parameter int CW = 8);
	logic start;
	logic [CW-1:0] count;
	modport timer(input start, output count);
	modport user(output start, input count);
endinterface

// File: src/sodw_cycle_timer.sv
// edge counter: counts clock edges since the last start pulse
// assumes start is a one-cycle pulse synchronous to clk
`include "sodw_defines.svh"
module sodw_cycle_timer
	import sodw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	sodw_tmr_if.timer t
);

	typedef struct packed {
		logic [`SODW_CNT_W-1:0] cnt;
	} sodw_tmr_state_t;

	sodw_tmr_state_t cur_reg;
	sodw_tmr_state_t cur_next;

	// =====================================================
	// counter
	always_comb begin
		cur_next = cur_reg;
		cur_next.cnt = sodw_next_count(cur_reg.cnt, t.start);
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			cur_reg <= '0;
		else
			cur_reg <= cur_next;
	end

	assign t.count = cur_reg.cnt;

	// =====================================================
	// checks
	a_start_loads_one: assert property (@(posedge clk) disable iff (!rst_b)
		t.start |=> t.count == `SODW_CNT_W'(1))
		else $error("timer did not restart at one");

endmodule // sodw_cycle_timer

// File: src/sodw_dyn_term.sv
// dynamic on-die termination control and controller timing checks
// assumes commands, termination_control and strobe_rise are sampled on clk
// Notes on behaviour
// - write termination starts write_latency minus 2 cycles after the write command
// - chop write returns to nominal 4 cycles plus turn-off latency after reference
// - full write returns to nominal 6 cycles plus turn-off latency after reference
// - every cycle limit counts actual input clock edges, one per cycle
`include "sodw_defines.svh"

module sodw_dyn_term
	import sodw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic termination_control,
	input wire logic wr_cmd,
	input wire logic wr_chop,
	input wire logic wr_term_en,
	input wire logic [4:0] write_latency,
	input wire logic wrlvl_mode,
	input wire logic strobe_rise,
	output logic [2:0] term_state,
	output logic odt_high_short_err,
	output logic wrlvl_strobe_early_err
);

	sodw_state_t cur_reg;
	sodw_state_t cur_next;

	sodw_tmr_if #(.CW(`SODW_CNT_W)) wr_tmr();
	sodw_tmr_if #(.CW(`SODW_CNT_W)) lvl_tmr();

	sodw_cycle_timer u_wr_timer (
		.clk(clk),
		.rst_b(rst_b),
		.t(wr_tmr.timer)
	);

	sodw_cycle_timer u_lvl_timer (
		.clk(clk),
		.rst_b(rst_b),
		.t(lvl_tmr.timer)
	);

	logic [4:0] skew_on;
	logic [5:0] skew_off;
	logic [`SODW_CNT_W-1:0] wr_cnt_next;
	logic odt_dly;
	logic in_win;

	// turn-off latency equals the turn-on delay here, so both use write_latency - 2
	assign skew_on = (write_latency > `SODW_NOM_TO_WRITE_SUB) ?
		write_latency - `SODW_NOM_TO_WRITE_SUB : 5'h00;

	assign wr_tmr.start = wr_cmd;
	assign lvl_tmr.start = wrlvl_mode && !cur_reg.wrlvl_q;

	// =====================================================
	// next state
	always_comb begin
		cur_next = cur_reg;
		cur_next.hist = {cur_reg.hist[`SODW_HIST_W-2:0], termination_control};
		odt_dly = cur_next.hist[skew_on];
		cur_next.dly = odt_dly;

		if (wr_cmd) begin
			cur_next.wr_active = 1'b1;
			cur_next.chop = wr_chop;
		end
		wr_cnt_next = sodw_next_count(wr_tmr.count, wr_cmd);
		skew_off = {1'b0, skew_on} + (cur_next.chop ? `SODW_WRITE_TO_NOM_CHOP :
			`SODW_WRITE_TO_NOM_FULL);

		// a write landing inside a window keeps write termination up, no glitch
		// wr_cnt_next already counts the command edge, so the lower compare is strict and the upper one inclusive
		in_win = cur_next.wr_active && wr_cnt_next <= `SODW_CNT_W'(skew_off) &&
			(wr_cnt_next > `SODW_CNT_W'(skew_on) ||
			cur_reg.term == SODW_TERM_WR);
		if (cur_next.wr_active && wr_cnt_next > `SODW_CNT_W'(skew_off))
			cur_next.wr_active = 1'b0;

		if (odt_dly && in_win && wr_term_en)
			cur_next.term = SODW_TERM_WR;
		else if (odt_dly)
			cur_next.term = SODW_TERM_NOM;
		else
			cur_next.term = SODW_TERM_OFF;

		// high-time check on termination_control
		if (termination_control) begin
			if (!cur_reg.hist[0]) begin
				cur_next.hi_cnt = 4'h1;
				cur_next.hi_long = wr_cmd && !wr_chop;
			end else begin
				if (cur_reg.hi_cnt != 4'hf)
					cur_next.hi_cnt = cur_reg.hi_cnt + 4'h1;
				if (wr_cmd && !wr_chop)
					cur_next.hi_long = 1'b1;
			end
		end else if (cur_reg.hist[0]) begin
			if (cur_reg.hi_cnt < (cur_reg.hi_long ? `SODW_ODT_HIGH_MIN_LONG :
				`SODW_ODT_HIGH_MIN_SHORT))
				cur_next.odt_err = 1'b1;
			cur_next.hi_cnt = 4'h0;
			cur_next.hi_long = 1'b0;
		end

		// strobe too soon after entering write leveling
		cur_next.wrlvl_q = wrlvl_mode;
		if (wrlvl_mode && cur_reg.wrlvl_q && strobe_rise &&
			lvl_tmr.count < `SODW_WRLVL_FIRST_STROBE_WAIT)
			cur_next.lvl_err = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cur_reg <= '0;
			cur_reg.term <= SODW_TERM_OFF;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign term_state = cur_reg.term;
	assign odt_high_short_err = cur_reg.odt_err;
	assign wrlvl_strobe_early_err = cur_reg.lvl_err;

	// =====================================================
	// checks; write_latency is taken as static while writes are in flight
	sequence s_full_write;
		wr_cmd && !wr_chop;
	endsequence

	sequence s_chop_write;
		wr_cmd && wr_chop;
	endsequence

	property p_restart_from(s);
		@(posedge clk) disable iff (!rst_b)
		s |=> wr_tmr.count == `SODW_CNT_W'(1) && cur_reg.wr_active;
	endproperty

	a_write_restarts: assert property (p_restart_from(s_full_write))
		else $error("write did not restart the skew count");

	a_chop_restarts: assert property (p_restart_from(s_chop_write))
		else $error("chop write did not restart the skew count");

	a_write_term_on: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(cur_reg.term == SODW_TERM_WR) && $past(cur_reg.dly) && !$past(wr_cmd) |->
		wr_tmr.count == `SODW_CNT_W'(skew_on) + `SODW_CNT_W'(1))
		else $error("write termination started at wrong skew");

	a_chop_return: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(cur_reg.term == SODW_TERM_WR) && cur_reg.dly && cur_reg.chop &&
		$stable(wr_term_en) && !$past(wr_cmd) |->
		wr_tmr.count == `SODW_CNT_W'(skew_on) + `SODW_CNT_W'(`SODW_WRITE_TO_NOM_CHOP) +
		`SODW_CNT_W'(1))
		else $error("chop write termination ended at wrong skew");

	a_full_return: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(cur_reg.term == SODW_TERM_WR) && cur_reg.dly && !cur_reg.chop &&
		$stable(wr_term_en) && !$past(wr_cmd) |->
		wr_tmr.count == `SODW_CNT_W'(skew_on) + `SODW_CNT_W'(`SODW_WRITE_TO_NOM_FULL) +
		`SODW_CNT_W'(1))
		else $error("full write termination ended at wrong skew");

	a_count_per_edge: assert property (@(posedge clk) disable iff (!rst_b)
		!wr_cmd && wr_tmr.count != '0 && wr_tmr.count != `SODW_CNT_MAX |=>
		wr_tmr.count == $past(wr_tmr.count) + `SODW_CNT_W'(1))
		else $error("skew count skipped a clock edge");

	// pulse shapes for the high-time flag, one sample per edge
	sequence s_odt_rise;
		!cur_reg.hist[0] && termination_control;
	endsequence

	sequence s_short_high;
		s_odt_rise ##1 termination_control [*2] ##1 !termination_control;
	endsequence

	sequence s_long_short_high;
		s_odt_rise ##1 termination_control && wr_cmd && !wr_chop ##1
			termination_control [*3] ##1 !termination_control;
	endsequence

	sequence s_lvl_entry;
		wrlvl_mode && !cur_reg.wrlvl_q;
	endsequence

	a_short_high_flag: assert property (@(posedge clk) disable iff (!rst_b)
		s_short_high |=> cur_reg.odt_err)
		else $error("short termination_control pulse not flagged");

	a_long_high_flag: assert property (@(posedge clk) disable iff (!rst_b)
		s_long_short_high |=> cur_reg.odt_err)
		else $error("short pulse with full write not flagged");

	// error flags are sticky; only a reset may clear them
	a_odt_err_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		cur_reg.odt_err |=> cur_reg.odt_err)
		else $error("high-time flag cleared without reset");

	a_lvl_err_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		cur_reg.lvl_err |=> cur_reg.lvl_err)
		else $error("leveling flag cleared without reset");

	// leveling checks only count while the mode is on
	a_lvl_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		!wrlvl_mode |=> $stable(cur_reg.lvl_err))
		else $error("leveling flag moved outside leveling mode");

	a_lvl_late_ok: assert property (@(posedge clk) disable iff (!rst_b)
		wrlvl_mode && cur_reg.wrlvl_q && strobe_rise && !cur_reg.lvl_err &&
		lvl_tmr.count >= `SODW_WRLVL_FIRST_STROBE_WAIT |=> !cur_reg.lvl_err)
		else $error("strobe after the leveling wait was flagged");

	a_lvl_restart: assert property (@(posedge clk) disable iff (!rst_b)
		s_lvl_entry |=> lvl_tmr.count == `SODW_CNT_W'(1))
		else $error("leveling entry did not restart the count");

	a_write_needs_en: assert property (@(posedge clk) disable iff (!rst_b)
		cur_reg.term == SODW_TERM_WR |-> $past(wr_term_en))
		else $error("write termination while disabled");

	a_write_needs_dly: assert property (@(posedge clk) disable iff (!rst_b)
		cur_reg.term == SODW_TERM_WR |-> cur_reg.dly)
		else $error("write termination without delayed request");

endmodule // sodw_dyn_term

// File: sim/sodw_ctrl_model.sv
// controller model: drives termination_control, writes and leveling strobes
// assumes one clock; every drive lands 1 ns after the rising edge
module sodw_ctrl_model (
	input wire logic clk,
	output logic termination_control,
	output logic wr_cmd,
	output logic wr_chop,
	output logic wrlvl_mode,
	output logic strobe_rise
);
	timeunit 1ns;
	timeprecision 100ps;
	int hi_n = 0;
	int lvl_n = 0;
	logic long_wr = 1'b0;
	initial begin
		{termination_control, wr_cmd, wr_chop, wrlvl_mode, strobe_rise} = 5'h00;
	end
	// ==========================================
	// edge counts, whole cycles only
	always @(posedge clk) begin
		hi_n <= termination_control ? hi_n + 1 : 0;
		lvl_n <= wrlvl_mode ? lvl_n + 1 : 0;
		if (!termination_control)
			long_wr <= 1'b0;
		else if (wr_cmd && !wr_chop)
			long_wr <= 1'b1;
	end
	task step;
		@(posedge clk);
		#1;
	endtask
	task odt_on;
		termination_control = 1'b1;
		step;
	endtask
	task wr(input logic chop);
		wr_cmd = 1'b1;
		wr_chop = chop;
		step;
		wr_cmd = 1'b0;
	endtask
	// n=0 keeps the minimum high time; n>0 drops after n samples on purpose
	task odt_off(input int n);
		while (n ? hi_n < n : hi_n < (long_wr ? 6 : 4)) step;
		termination_control = 1'b0;
		step;
	endtask
	// k=0 keeps the leveling wait; k>0 strobes k edges after entry
	task level(input int k);
		wrlvl_mode = 1'b1;
		while (lvl_n < (k ? k : 40)) step;
		strobe_rise = 1'b1;
		step;
		strobe_rise = 1'b0;
		repeat (2) step;
		wrlvl_mode = 1'b0;
	endtask
endmodule // sodw_ctrl_model

// File: sim/tb_sodw_dyn_term.sv
// self-checking bench for sodw_dyn_term
// assumes the controller model in sodw_ctrl_model.sv
module tb_sodw_dyn_term;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_b, wr_term_en, odt_high_short_err, wrlvl_strobe_early_err;
	logic termination_control, wr_cmd, wr_chop, wrlvl_mode, strobe_rise;
	logic [4:0] write_latency;
	logic [2:0] term_state;
	logic [4:0] write_latency_set[2] = '{5'h05, 5'h09};
	int err_total = 0;
	int checks_done = 0;
	sodw_ctrl_model u_ctrl (.clk(clk), .termination_control(termination_control),
		.wr_cmd(wr_cmd), .wr_chop(wr_chop), .wrlvl_mode(wrlvl_mode), .strobe_rise(strobe_rise));
	sodw_dyn_term u_dut (.clk(clk), .rst_b(rst_b), .termination_control(termination_control),
		.wr_cmd(wr_cmd), .wr_chop(wr_chop), .wr_term_en(wr_term_en),
		.write_latency(write_latency), .wrlvl_mode(wrlvl_mode), .strobe_rise(strobe_rise),
		.term_state(term_state), .odt_high_short_err(odt_high_short_err),
		.wrlvl_strobe_early_err(wrlvl_strobe_early_err));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ==========================================
	// checking and closing
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task reset_dut(input int n);
		rst_b = 1'b0;
		repeat (n) u_ctrl.step;
		rst_b = 1'b1;
		chk(term_state, 8'h01);
	endtask
	// ==========================================
	// scenarios
	task t_write(input logic chop);
		int d;
		d = write_latency - 5'h02;
		u_ctrl.odt_on;
		repeat (d + 2) u_ctrl.step;
		chk(term_state, 8'h02);
		u_ctrl.wr(chop);
		repeat (d - 1) u_ctrl.step;
		chk(term_state, 8'h02);
		u_ctrl.step;
		chk(term_state, 8'h04);
		repeat (chop ? 3 : 5) u_ctrl.step;
		chk(term_state, 8'h04);
		u_ctrl.step;
		chk(term_state, 8'h02);
		u_ctrl.odt_off(0);
		repeat (d + 1) u_ctrl.step;
		chk(term_state, 8'h01);
		chk(odt_high_short_err, 8'h00);
		$display("write chop=%0d latency=%0d done", chop, write_latency);
	endtask
	task t_high_time;
		int n[5] = '{4, 3, 5, 6, 4};
		int w[5] = '{0, 0, 1, 1, 2};
		logic e[5] = '{0, 1, 1, 0, 0};
		for (int i = 0; i < 5; i++) begin
			reset_dut(8);
			u_ctrl.odt_on;
			if (w[i] != 0)
				u_ctrl.wr(w[i] == 2);
			u_ctrl.odt_off(n[i]);
			repeat (2) u_ctrl.step;
			chk(odt_high_short_err, e[i]);
		end
		$display("high time done");
	endtask
	task t_level;
		reset_dut(8);
		u_ctrl.level(39);
		chk(wrlvl_strobe_early_err, 8'h01);
		reset_dut(8);
		u_ctrl.level(0);
		chk(wrlvl_strobe_early_err, 8'h00);
		$display("leveling done");
	endtask
	task t_no_write_term;
		wr_term_en = 1'b0;
		u_ctrl.odt_on;
		repeat (8) u_ctrl.step;
		u_ctrl.wr(1'b0);
		repeat (10) begin
			u_ctrl.step;
			chk(term_state, 8'h02);
		end
		u_ctrl.odt_off(0);
		// let the write window close before enabling again
		repeat (write_latency + 6) u_ctrl.step;
		wr_term_en = 1'b1;
		$display("refused write termination done");
	endtask
	initial begin
		rst_b = 1'b0;
		wr_term_en = 1'b1;
		write_latency = 5'h05;
		reset_dut(6);
		foreach (write_latency_set[i]) begin
			write_latency = write_latency_set[i];
			reset_dut(12);
			t_write(1'b0);
			t_write(1'b1);
		end
		t_no_write_term;
		t_high_time;
		t_level;
		give_verdict;
	end
	// bounded run: running out counts as a mismatch
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		give_verdict;
	end
endmodule // tb_sodw_dyn_term
